// [rtl/eie_core.sv]
// Extended instruction execute core with APB register access
//
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "eie_defs.svh"

module eie_core #(
  parameter int DM_DEPTH = 256
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // APB slave
  input wire eie_pkg::eie_apb_req_t apbReq,
  output var eie_pkg::eie_apb_rsp_t apbRsp,
  // Program memory read port
  output logic [15:0] progAddr,
  output logic progRd,
  input wire logic [15:0] progData,
  // Execution status
  output logic busy,
  output logic skipPulse,
  output logic donePulse
);
  import eie_pkg::*;

  eie_regs_t r;
  eie_regs_t next_r;
  logic [7:0] dmem [DM_DEPTH];
  logic memWe;
  logic [7:0] memWa;
  logic [7:0] memWd;
  logic [7:0] opnd;
  logic [7:0] ptrData;
  logic [7:0] mask;
  logic withCarry;
  logic borrowIn;
  logic [8:0] diff;
  logic [4:0] nibDiff;
  eie_flags_t subFlags;
  logic skip;
  logic setup;
  logic access;
  logic refuse;
  logic [31:0] rdData;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Addresses beyond the array read as zero and drop writes
  function automatic logic memOk(input logic [7:0] a);
    memOk = (32'(a) < DM_DEPTH);
  endfunction

  function automatic logic [7:0] rotR(input logic [7:0] v, input logic top);
    rotR = {top, v[7:1]};
  endfunction

  function automatic logic [7:0] swapNib(input logic [7:0] v);
    swapNib = {v[3:0], v[7:4]};
  endfunction

  function automatic logic regHit(input logic [7:0] a);
    if (a == `EIE_OFF_CMD) begin
      regHit = 1'b1;
    end else if (a == `EIE_OFF_ACC) begin
      regHit = 1'b1;
    end else if (a == `EIE_OFF_FLAGS) begin
      regHit = 1'b1;
    end else if (a == `EIE_OFF_TABLE_POINTER_LOW) begin
      regHit = 1'b1;
    end else if (a == `EIE_OFF_TABLE_POINTER_HIGH) begin
      regHit = 1'b1;
    end else if (a == `EIE_OFF_TABLE_HIGH_LATCH) begin
      regHit = 1'b1;
    end else if (a == `EIE_OFF_MPTR) begin
      regHit = 1'b1;
    end else if (a == `EIE_OFF_MDATA) begin
      regHit = 1'b1;
    end else begin
      regHit = 1'b0;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_r = r;
    next_r.skipPulse = 1'b0;
    next_r.donePulse = 1'b0;
    next_r.progRd = 1'b0;
    skip = 1'b0;
    memWe = 1'b0;
    memWa = r.cmd.addr;
    opnd = memOk(r.cmd.addr) ? dmem[r.cmd.addr] : 8'h00;
    ptrData = memOk(r.mptr) ? dmem[r.mptr] : 8'h00;
    memWd = opnd;
    mask = 8'h01 << r.cmd.bitSel;

    // Shared subtractor; carry holds the inverted borrow
    withCarry = (r.cmd.op == OP_SUBB_ACC) || (r.cmd.op == OP_SUBB_MEM);
    borrowIn = withCarry & ~r.flags.c;
    diff = {1'b0, r.acc} - {1'b0, opnd} - {8'h00, borrowIn};
    nibDiff = {1'b0, r.acc[3:0]} - {1'b0, opnd[3:0]} - {4'h0, borrowIn};
    subFlags.c = ~diff[8];
    subFlags.ac = ~nibDiff[4];
    subFlags.ov = (r.acc[7] ^ opnd[7]) & (diff[7] ^ r.acc[7]);
    subFlags.z = (diff[7:0] == 8'h00);
    subFlags.sc = ~(diff[7] ^ subFlags.ov);
    // Chained zero only narrows across borrow subtractions
    subFlags.cz = withCarry ? (r.flags.z & subFlags.z) : subFlags.z;

    case (r.fsm)
      S_IDLE: begin
      end
      S_EXEC: begin
        case (r.cmd.op)
          OP_ROTR_MEM: begin
            memWe = 1'b1;
            memWd = rotR(opnd, opnd[0]);
          end
          OP_ROTR_ACC: begin
            next_r.acc = rotR(opnd, opnd[0]);
          end
          OP_ROTRC_MEM: begin
            memWe = 1'b1;
            memWd = rotR(opnd, r.flags.c);
            next_r.flags.c = opnd[0];
          end
          OP_ROTRC_ACC: begin
            next_r.acc = rotR(opnd, r.flags.c);
            next_r.flags.c = opnd[0];
          end
          OP_SUBB_ACC: begin
            next_r.acc = diff[7:0];
            next_r.flags = subFlags;
          end
          OP_SUBB_MEM: begin
            memWe = 1'b1;
            memWd = diff[7:0];
            next_r.flags = subFlags;
          end
          OP_SUB_ACC: begin
            next_r.acc = diff[7:0];
            next_r.flags = subFlags;
          end
          OP_SUB_MEM: begin
            memWe = 1'b1;
            memWd = diff[7:0];
            next_r.flags = subFlags;
          end
          OP_DECSZ_MEM: begin
            memWe = 1'b1;
            memWd = opnd - 8'h01;
            skip = (opnd == 8'h01);
          end
          OP_DECSZ_ACC: begin
            next_r.acc = opnd - 8'h01;
            skip = (opnd == 8'h01);
          end
          OP_INCSZ_MEM: begin
            memWe = 1'b1;
            memWd = opnd + 8'h01;
            skip = (opnd == `EIE_ALL_ONES);
          end
          OP_INCSZ_ACC: begin
            next_r.acc = opnd + 8'h01;
            skip = (opnd == `EIE_ALL_ONES);
          end
          OP_SET_BYTE: begin
            memWe = 1'b1;
            memWd = `EIE_ALL_ONES;
          end
          OP_SET_BIT: begin
            memWe = 1'b1;
            memWd = opnd | mask;
          end
          OP_SKNZ_BIT: begin
            skip = |(opnd & mask);
          end
          OP_SKNZ_BYTE: begin
            // Read and rewrite keeps the memory access pattern of the core
            memWe = 1'b1;
            memWd = opnd;
            skip = (opnd != 8'h00);
          end
          OP_SKZ_BYTE: begin
            memWe = 1'b1;
            memWd = opnd;
            skip = (opnd == 8'h00);
          end
          OP_SKZ_MOVE: begin
            next_r.acc = opnd;
            skip = (opnd == 8'h00);
          end
          OP_SKZ_BIT: begin
            skip = ~|(opnd & mask);
          end
          OP_SWAP_MEM: begin
            memWe = 1'b1;
            memWd = swapNib(opnd);
          end
          OP_SWAP_ACC: begin
            next_r.acc = swapNib(opnd);
          end
          OP_TBL_READ: begin
            next_r.progAddr = {r.table_pointer_high, r.table_pointer_low};
            next_r.progRd = 1'b1;
          end
          default: begin
          end
        endcase
        if (r.cmd.op == OP_TBL_READ) begin
          next_r.fsm = S_TBL_WAIT;
        end else if (skip) begin
          next_r.fsm = S_FETCH;
          next_r.skipPulse = 1'b1;
          next_r.skipped = 1'b1;
          next_r.lastCyc = `EIE_CYC_SKIP;
        end else begin
          next_r.fsm = S_IDLE;
          next_r.donePulse = 1'b1;
          next_r.lastCyc = `EIE_CYC_NORMAL;
        end
      end
      S_FETCH: begin
        // Next instruction is fetched and then discarded
        next_r.fsm = S_DUMMY;
      end
      S_DUMMY: begin
        next_r.fsm = S_IDLE;
        next_r.donePulse = 1'b1;
      end
      S_TBL_WAIT: begin
        // Program memory answers one cycle after the address
        next_r.fsm = S_TBL_CAP;
      end
      S_TBL_CAP: begin
        memWe = 1'b1;
        memWd = progData[7:0];
        next_r.table_high_latch = progData[15:8];
        next_r.lastCyc = `EIE_CYC_TABLE;
        next_r.donePulse = 1'b1;
        next_r.fsm = S_IDLE;
      end
      default: begin
        next_r.fsm = S_IDLE;
      end
    endcase

    //////////////////////////////////////////////////////////////////////////
    // APB slave: answer one cycle after setup

    setup = apbReq.psel & ~apbReq.penable;
    access = apbReq.psel & apbReq.penable & r.rsp.pready;
    rdData = 32'h0;
    if (apbReq.paddr == `EIE_OFF_CMD) begin
      rdData[`EIE_CMD_OP_LSB +: 5] = r.cmd.op;
      rdData[`EIE_CMD_BIT_LSB +: 3] = r.cmd.bitSel;
      rdData[`EIE_CMD_ADDR_LSB +: 8] = r.cmd.addr;
    end else if (apbReq.paddr == `EIE_OFF_ACC) begin
      rdData[7:0] = r.acc;
    end else if (apbReq.paddr == `EIE_OFF_FLAGS) begin
      rdData[`EIE_FL_C] = r.flags.c;
      rdData[`EIE_FL_AC] = r.flags.ac;
      rdData[`EIE_FL_Z] = r.flags.z;
      rdData[`EIE_FL_OV] = r.flags.ov;
      rdData[`EIE_FL_SC] = r.flags.sc;
      rdData[`EIE_FL_CZ] = r.flags.cz;
      rdData[`EIE_ST_BUSY] = r.busy;
      rdData[`EIE_ST_SKIP] = r.skipped;
      rdData[`EIE_ST_CYC_LSB +: 2] = r.lastCyc;
    end else if (apbReq.paddr == `EIE_OFF_TABLE_POINTER_LOW) begin
      rdData[7:0] = r.table_pointer_low;
    end else if (apbReq.paddr == `EIE_OFF_TABLE_POINTER_HIGH) begin
      rdData[7:0] = r.table_pointer_high;
    end else if (apbReq.paddr == `EIE_OFF_TABLE_HIGH_LATCH) begin
      rdData[7:0] = r.table_high_latch;
    end else if (apbReq.paddr == `EIE_OFF_MPTR) begin
      rdData[7:0] = r.mptr;
    end else if (apbReq.paddr == `EIE_OFF_MDATA) begin
      rdData[7:0] = ptrData;
    end

    // Writes while busy are refused so software never races execution
    refuse = ~regHit(apbReq.paddr);
    if (apbReq.pwrite) begin
      if (r.busy) begin
        refuse = 1'b1;
      end else if (apbReq.paddr == `EIE_OFF_TABLE_HIGH_LATCH) begin
        refuse = 1'b1;
      end else if (apbReq.paddr == `EIE_OFF_CMD) begin
        if (apbReq.pwdata[`EIE_CMD_OP_LSB +: 5] >= `EIE_OP_COUNT) begin
          refuse = 1'b1;
        end
      end
    end

    next_r.rsp.pready = setup;
    if (setup) begin
      next_r.rsp.prdata = apbReq.pwrite ? 32'h0 : rdData;
      next_r.rsp.pslverr = refuse;
    end

    if (access && apbReq.pwrite && !r.rsp.pslverr) begin
      if (apbReq.paddr == `EIE_OFF_CMD) begin
        next_r.cmd.op = eie_op_t'(apbReq.pwdata[`EIE_CMD_OP_LSB +: 5]);
        next_r.cmd.bitSel = apbReq.pwdata[`EIE_CMD_BIT_LSB +: 3];
        next_r.cmd.addr = apbReq.pwdata[`EIE_CMD_ADDR_LSB +: 8];
        next_r.skipped = 1'b0;
        next_r.fsm = S_EXEC;
      end else if (apbReq.paddr == `EIE_OFF_ACC) begin
        next_r.acc = apbReq.pwdata[7:0];
      end else if (apbReq.paddr == `EIE_OFF_FLAGS) begin
        next_r.flags.c = apbReq.pwdata[`EIE_FL_C];
        next_r.flags.ac = apbReq.pwdata[`EIE_FL_AC];
        next_r.flags.z = apbReq.pwdata[`EIE_FL_Z];
        next_r.flags.ov = apbReq.pwdata[`EIE_FL_OV];
        next_r.flags.sc = apbReq.pwdata[`EIE_FL_SC];
        next_r.flags.cz = apbReq.pwdata[`EIE_FL_CZ];
      end else if (apbReq.paddr == `EIE_OFF_TABLE_POINTER_LOW) begin
        next_r.table_pointer_low = apbReq.pwdata[7:0];
      end else if (apbReq.paddr == `EIE_OFF_TABLE_POINTER_HIGH) begin
        next_r.table_pointer_high = apbReq.pwdata[7:0];
      end else if (apbReq.paddr == `EIE_OFF_MPTR) begin
        next_r.mptr = apbReq.pwdata[7:0];
      end else if (apbReq.paddr == `EIE_OFF_MDATA) begin
        memWe = 1'b1;
        memWa = r.mptr;
        memWd = apbReq.pwdata[7:0];
      end
    end

    next_r.busy = (next_r.fsm != S_IDLE);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      r <= '0;
      r.fsm <= S_IDLE;
      r.acc <= `EIE_ACC_RST;
      r.flags <= `EIE_FLAGS_RST;
      r.table_pointer_low <= `EIE_TBL_RST;
      r.table_pointer_high <= `EIE_TBL_RST;
      r.table_high_latch <= `EIE_TBL_RST;
    end else begin
      r <= next_r;
    end
  end

  // Data memory has no reset; software initialises it through the window
  always_ff @(posedge mclk) begin
    if (rst_b && memWe && memOk(memWa)) begin
      dmem[memWa] <= memWd;
    end
  end

  assign apbRsp = r.rsp;
  assign progAddr = r.progAddr;
  assign progRd = r.progRd;
  assign busy = r.busy;
  assign skipPulse = r.skipPulse;
  assign donePulse = r.donePulse;

endmodule // eie_core
`default_nettype wire

// [rtl/eie_defs.svh]
// Constants for the extended instruction execute block
`ifndef EIE_DEFS_SVH
`define EIE_DEFS_SVH
`define EIE_OFF_CMD 8'h00
`define EIE_OFF_ACC 8'h04
`define EIE_OFF_FLAGS 8'h08
`define EIE_OFF_TABLE_POINTER_LOW 8'h0c
`define EIE_OFF_TABLE_POINTER_HIGH 8'h10
`define EIE_OFF_TABLE_HIGH_LATCH 8'h14
`define EIE_OFF_MPTR 8'h18
`define EIE_OFF_MDATA 8'h1c
`define EIE_CMD_OP_LSB 0
`define EIE_CMD_BIT_LSB 8
`define EIE_CMD_ADDR_LSB 16
`define EIE_FL_C 0
`define EIE_FL_AC 1
`define EIE_FL_Z 2
`define EIE_FL_OV 3
`define EIE_FL_SC 4
`define EIE_FL_CZ 5
`define EIE_ST_BUSY 8
`define EIE_ST_SKIP 9
`define EIE_ST_CYC_LSB 10
`define EIE_ACC_RST 8'h00
`define EIE_FLAGS_RST 6'h00
`define EIE_TBL_RST 8'h00
`define EIE_CYC_NORMAL 2'h1
`define EIE_CYC_SKIP 2'h3
`define EIE_CYC_TABLE 2'h3
`define EIE_ALL_ONES 8'hff
`define EIE_OP_COUNT 5'h16
`endif

// [rtl/eie_pkg.sv]
// Types for the extended instruction execute block
package eie_pkg;
  typedef enum logic [4:0] {
    OP_ROTR_MEM, OP_ROTR_ACC, OP_ROTRC_MEM, OP_ROTRC_ACC,
    OP_SUBB_ACC, OP_SUBB_MEM, OP_SUB_ACC, OP_SUB_MEM,
    OP_DECSZ_MEM, OP_DECSZ_ACC, OP_INCSZ_MEM, OP_INCSZ_ACC,
    OP_SET_BYTE, OP_SET_BIT, OP_SKNZ_BIT, OP_SKNZ_BYTE,
    OP_SKZ_BYTE, OP_SKZ_MOVE, OP_SKZ_BIT, OP_SWAP_MEM,
    OP_SWAP_ACC, OP_TBL_READ
  } eie_op_t;
  typedef enum logic [2:0] {
    S_IDLE, S_EXEC, S_FETCH, S_DUMMY, S_TBL_WAIT, S_TBL_CAP
  } eie_fsm_t;
  typedef struct packed {
    logic cz; logic sc; logic ov; logic z; logic ac; logic c;
  } eie_flags_t;
  typedef struct packed {
    eie_op_t op; logic [2:0] bitSel; logic [7:0] addr;
  } eie_cmd_t;
  typedef struct packed {
    logic psel; logic penable; logic pwrite;
    logic [7:0] paddr; logic [31:0] pwdata;
  } eie_apb_req_t;
  typedef struct packed {
    logic [31:0] prdata; logic pready; logic pslverr;
  } eie_apb_rsp_t;
  typedef struct packed {
    eie_fsm_t fsm; eie_cmd_t cmd; logic [7:0] acc; eie_flags_t flags;
    logic [7:0] table_pointer_low; logic [7:0] table_pointer_high; logic [7:0] table_high_latch; logic [7:0] mptr;
    eie_apb_rsp_t rsp; logic busy; logic skipped; logic [1:0] lastCyc;
    logic skipPulse; logic donePulse; logic [15:0] progAddr; logic progRd;
  } eie_regs_t;
endpackage

// [tb/eie_chk_sva.sv]
// Port assertions for the extended instruction execute core
`timescale 1ns/1ps
`default_nettype none
module eie_chk (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Register bus and status
  input wire eie_pkg::eie_apb_req_t apbReq,
  input wire eie_pkg::eie_apb_rsp_t apbRsp,
  input wire logic [15:0] progAddr,
  input wire logic progRd,
  input wire logic busy,
  input wire logic skipPulse,
  input wire logic donePulse
);
  import eie_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  logic setup;
  assign setup = apbReq.psel && !apbReq.penable;
  ////////////////////////////////////////////////////////////////////////////////
  apb_answer_a: assert property (setup |=> apbRsp.pready)
    else $error("no ready after setup");
  bad_addr_a: assert property (setup && (apbReq.paddr[1:0] != 2'h0 || apbReq.paddr > 8'h1c)
    |=> apbRsp.pready && apbRsp.pslverr) else $error("unmapped not refused");
  cmd_start_a: assert property (apbReq.psel && apbReq.penable && apbReq.pwrite &&
    apbRsp.pready && !apbRsp.pslverr && apbReq.paddr == 8'h00 |=> busy && !donePulse)
    else $error("command did not start");
  normal_end_a: assert property ($rose(busy) |=> (!busy && donePulse) || skipPulse || progRd)
    else $error("plain op not one cycle");
  skip_len_a: assert property (skipPulse |=> busy ##1 (!busy && donePulse))
    else $error("skip not three cycles");
  table_len_a: assert property (progRd |-> busy ##1 (busy && !progRd)
    ##1 (!busy && donePulse)) else $error("table read timing");
  prog_hold_a: assert property ($past(rst_b) && $changed(progAddr) |-> progRd)
    else $error("program address moved");
  done_idle_a: assert property (donePulse |-> !busy && !skipPulse)
    else $error("done while busy");
  cover property (skipPulse);
  cover property (progRd);
  cover property (apbRsp.pready && apbRsp.pslverr);
  cover property (donePulse);
endmodule // eie_chk
bind eie_core eie_chk u_chk (.mclk(mclk), .rst_b(rst_b), .apbReq(apbReq), .apbRsp(apbRsp),
  .progAddr(progAddr), .progRd(progRd), .busy(busy), .skipPulse(skipPulse),
  .donePulse(donePulse));
`default_nettype wire

// [tb/extended_instruction_execute_tb_top.sv]
// Self-checking bench for the extended instruction execute core
`timescale 1ns/1ps
`default_nettype none
`include "eie_defs.svh"
module extended_instruction_execute_tb_top;
  import eie_pkg::*;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  eie_apb_req_t apbReq = '0;
  eie_apb_rsp_t apbRsp;
  logic [15:0] progAddr;
  logic [15:0] progData = 16'h0000;
  logic progRd, busy, skipPulse, donePulse, rerr, skipSeen, doneSeen;
  logic [31:0] seed = 32'd75;
  logic [31:0] rdat;
  int nErrors = 0;
  int numChecks = 0;
  int busyCnt;
  eie_core u_eie_core (.mclk(mclk), .rst_b(rst_b), .apbReq(apbReq), .apbRsp(apbRsp),
    .progAddr(progAddr), .progRd(progRd), .progData(progData), .busy(busy),
    .skipPulse(skipPulse), .donePulse(donePulse));
  always #4 mclk = ~mclk;
  // Program word is a scramble of its address, so reads are predictable
  always @(posedge mclk) begin
    progData <= progAddr ^ 16'h5a3c;
    if (busy === 1'b1) busyCnt++;
    if (skipPulse === 1'b1) skipSeen = 1'b1;
    if (donePulse === 1'b1) doneSeen = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic giveVerdict();
    $display("checks %0d errors %0d", numChecks, nErrors);
    if (nErrors == 0 && numChecks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    numChecks++;
    if (g !== e) begin
      nErrors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    apbReq <= '{1'b1, 1'b0, w, a, d};
    @(posedge mclk);
    apbReq.penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (apbRsp.pready !== 1'b1 && n < 20);
    rdat = apbRsp.prdata;
    rerr = apbRsp.pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
    if (n >= 20) begin
      nErrors++;
      giveVerdict();
    end
  endtask
  // Result is {skip, flags, acc, mem}
  function automatic logic [22:0] model(input eie_op_t op, input logic [2:0] bs,
      input logic [7:0] a, input logic [7:0] m, input eie_flags_t f, input logic [15:0] tw);
    logic [8:0] d;
    logic [4:0] n;
    logic bw;
    logic sk;
    logic [7:0] ra;
    logic [7:0] rm;
    eie_flags_t g;
    g = f;
    ra = a;
    rm = m;
    sk = 1'b0;
    bw = (op == OP_SUBB_ACC || op == OP_SUBB_MEM) & ~f.c;
    d = {1'b0, a} - {1'b0, m} - {8'h00, bw};
    n = {1'b0, a[3:0]} - {1'b0, m[3:0]} - {4'h0, bw};
    case (op)
      OP_ROTR_MEM: rm = {m[0], m[7:1]};
      OP_ROTR_ACC: ra = {m[0], m[7:1]};
      OP_ROTRC_MEM: {rm, g.c} = {f.c, m};
      OP_ROTRC_ACC: {ra, g.c} = {f.c, m};
      OP_SUBB_ACC, OP_SUB_ACC: ra = d[7:0];
      OP_SUBB_MEM, OP_SUB_MEM: rm = d[7:0];
      OP_DECSZ_MEM: {sk, rm} = {m == 8'h01, m - 8'h01};
      OP_DECSZ_ACC: {sk, ra} = {m == 8'h01, m - 8'h01};
      OP_INCSZ_MEM: {sk, rm} = {m == 8'hff, m + 8'h01};
      OP_INCSZ_ACC: {sk, ra} = {m == 8'hff, m + 8'h01};
      OP_SET_BYTE: rm = `EIE_ALL_ONES;
      OP_SET_BIT: rm[bs] = 1'b1;
      OP_SKNZ_BIT: sk = m[bs];
      OP_SKNZ_BYTE: sk = m != 8'h00;
      OP_SKZ_BYTE: sk = m == 8'h00;
      OP_SKZ_MOVE: {sk, ra} = {m == 8'h00, m};
      OP_SKZ_BIT: sk = ~m[bs];
      OP_SWAP_MEM: rm = {m[3:0], m[7:4]};
      OP_SWAP_ACC: ra = {m[3:0], m[7:4]};
      OP_TBL_READ: rm = tw[7:0];
      default: ;
    endcase
    if (op inside {[OP_SUBB_ACC:OP_SUB_MEM]}) begin
      g.c = ~d[8];
      g.ac = ~n[4];
      g.z = d[7:0] == 8'h00;
      g.ov = (a[7] != m[7]) && (d[7] != a[7]);
      g.sc = ~(d[7] ^ g.ov);
      g.cz = (op < OP_SUB_ACC) ? (f.z & g.z) : g.z;
    end
    return {sk, g, ra, rm};
  endfunction
  task automatic runOp(input eie_op_t op, input logic [7:0] a, input logic [7:0] m,
      input eie_flags_t f);
    logic [31:0] r;
    logic [15:0] tp;
    logic [22:0] ex;
    logic [1:0] cy;
    int n;
    r = xs();
    tp = r[31:16];
    ex = model(op, r[2:0], a, m, f, tp ^ 16'h5a3c);
    cy = ex[22] ? `EIE_CYC_SKIP : (op == OP_TBL_READ ? `EIE_CYC_TABLE : `EIE_CYC_NORMAL);
    apb(1'b1, 8'h04, {24'h0, a});
    apb(1'b1, 8'h08, {26'h0, f});
    apb(1'b1, 8'h18, {24'h0, r[10:3]});
    apb(1'b1, 8'h1c, {24'h0, m});
    apb(1'b1, 8'h0c, {24'h0, tp[7:0]});
    apb(1'b1, 8'h10, {24'h0, tp[15:8]});
    busyCnt = 0;
    skipSeen = 1'b0;
    doneSeen = 1'b0;
    apb(1'b1, 8'h00, {8'h00, r[10:3], 5'h00, r[2:0], 3'h0, op});
    chk("cmd refused", 0, rerr);
    // Same pointer value, so an accepted write changes nothing
    apb(1'b1, 8'h18, {24'h0, r[10:3]});
    chk("write while busy", cy != `EIE_CYC_NORMAL, rerr);
    n = 0;
    while (doneSeen !== 1'b1 && n < 40) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 40) begin
      nErrors++;
      giveVerdict();
    end
    chk("busy cycles", op == OP_TBL_READ ? 3 : (ex[22] ? 3 : 1), busyCnt);
    chk("skip pulse", ex[22], skipSeen);
    apb(1'b0, 8'h08, 0);
    chk("flags", {20'h0, cy, ex[22], 3'h0, ex[21:16]}, rdat);
    apb(1'b0, 8'h04, 0);
    chk("acc", {24'h0, ex[15:8]}, rdat);
    apb(1'b0, 8'h1c, 0);
    chk("mem", {24'h0, ex[7:0]}, rdat);
    if (op == OP_TBL_READ) begin
      apb(1'b0, 8'h14, 0);
      chk("table high", {24'h0, tp[15:8] ^ 8'h5a}, rdat);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] r;
    repeat (16) @(posedge mclk);
    rst_b <= 1'b1;
    apb(1'b0, 8'h04, 0);
    chk("acc reset", `EIE_ACC_RST, rdat);
    apb(1'b0, 8'h08, 0);
    chk("flags reset", 0, rdat);
    apb(1'b0, 8'h20, 0);
    chk("unmapped", 1, rerr);
    apb(1'b1, 8'h14, 32'hff);
    chk("latch write", 1, rerr);
    apb(1'b1, 8'h00, 32'h16);
    chk("bad opcode", 1, rerr);
    for (int i = 0; i < 132; i++) begin
      r = xs();
      case (i / 22)
        0: runOp(eie_op_t'(5'(i % 22)), 8'h00, 8'h01, '0);
        1: runOp(eie_op_t'(5'(i % 22)), 8'h80, 8'hff, '1);
        2: runOp(eie_op_t'(5'(i % 22)), 8'h7f, 8'h00, eie_flags_t'(r[5:0]));
        default: runOp(eie_op_t'(5'(i % 22)), r[15:8], r[23:16], eie_flags_t'(r[5:0]));
      endcase
    end
    giveVerdict();
  end
endmodule // extended_instruction_execute_tb_top
`default_nettype wire
